/* File: src/supervisor_pkg.sv */
// ==========================================================
// Shared constants for the supply and clock supervisor
package supervisor_pkg;
  // Clock period of sys_clk
  localparam int CLK_PERIOD_NS = 50;
  // Settling time for one comparator injection step (least time, rounded up)
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock monitor measurement window
  localparam int WINDOW_NS = 10000;
  localparam int WINDOW_CYC = WINDOW_NS / CLK_PERIOD_NS;
  // Nominal internal oscillator rate and allowed deviation
  localparam int OSC_NOMINAL_KHZ = 2000;
  localparam int OSC_TOL_PCT = 30;
  localparam int EDGE_NOM = OSC_NOMINAL_KHZ * WINDOW_NS / 1000000;
  localparam int EDGE_MIN = EDGE_NOM * (100 - OSC_TOL_PCT) / 100;
  localparam int EDGE_MAX = EDGE_NOM * (100 + OSC_TOL_PCT) / 100;
  // Startup clock monitor check lasts two windows plus margin
  localparam int CMBIST_CYC = 2 * WINDOW_CYC + 8;
  localparam int TIMER_W = 10;
  // Primary status bit positions
  localparam int PST_UV = 0;
  localparam int PST_OV = 1;
  localparam int PST_SELFTEST = 2;
  localparam int PST_CLKMON = 3;
  // Secondary status bit positions
  localparam int SST_POS_UV = 0;
  localparam int SST_POS_OV = 1;
  localparam int SST_NEG_UV = 2;
  localparam int SST_NEG_OV = 3;
  localparam int SST_SELFTEST = 4;
  localparam int SST_CLKMON = 5;
  // Regulator monitor injection codes
  localparam logic [1:0] INJ_NONE = 2'h0;
  localparam logic [1:0] INJ_UV = 2'h1;
  localparam logic [1:0] INJ_OV = 2'h2;
  // Simulated supply codes used during the comparator self-test
  localparam logic [7:0] SIM_LOW = 8'h00;
  localparam logic [7:0] SIM_HIGH = 8'hff;
  // Supervisor sequence
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_COMPARATOR_SELFTEST_UV = 3'h1,
    ST_COMPARATOR_SELFTEST_OV = 3'h2,
    ST_CMBIST = 3'h3,
    ST_RUN = 3'h4
  } supv_state_t;
endpackage

/* File: src/clock_monitor.sv */
`timescale 1ns/1ps
// ==========================================================
// Oscillator watchdog: counts rising edges per window
module clock_monitor #(
  parameter int WIN_CYC = supervisor_pkg::WINDOW_CYC,
  parameter int MIN_EDGES = supervisor_pkg::EDGE_MIN,
  parameter int MAX_EDGES = supervisor_pkg::EDGE_MAX
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic emulate,
  input wire logic oscPin,
  output logic fault
);
  localparam logic [9:0] WIN_LAST = 10'(WIN_CYC - 1);
  localparam logic [7:0] EMIN = 8'(MIN_EDGES);
  localparam logic [7:0] EMAX = 8'(MAX_EDGES);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prevLvl;
    logic emuPrev;
    logic [9:0] winCnt;
    logic [7:0] edgeCnt;
    logic fault;
  } mon_state_t;

  mon_state_t st_reg, st_next;
  logic lvl; // Observed level, forced low while emulating
  logic rise;
  logic [7:0] total;

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.sync1 = oscPin;
    st_next.sync2 = st_reg.sync1;
    lvl = st_reg.sync2 & ~emulate; // Emulation stalls the observed clock only
    rise = lvl & ~st_reg.prevLvl;
    st_next.prevLvl = lvl;
    st_next.emuPrev = emulate;
    st_next.fault = 1'b0;
    total = (st_reg.edgeCnt == 8'hff) ? 8'hff : st_reg.edgeCnt + {7'h00, rise};
    if (!enable || (emulate != st_reg.emuPrev)) begin
      // Restart so a window never mixes emulated and real edges
      st_next.winCnt = 10'h000;
      st_next.edgeCnt = 8'h00;
    end else if (st_reg.winCnt == WIN_LAST) begin
      // Zero edges covers stuck high and stuck low
      st_next.fault = (total < EMIN) || (total > EMAX);
      st_next.winCnt = 10'h000;
      st_next.edgeCnt = 8'h00;
    end else begin
      st_next.winCnt = st_reg.winCnt + 10'h001;
      st_next.edgeCnt = total;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fault = st_reg.fault;
endmodule

/* File: src/supply_clock_fault_supervisor.sv */
`timescale 1ns/1ps
// What this block does
// - Power up needs valid primary supply, secondary positive above its UV threshold
// - Driver off, gate held low from first clock after reset until supplies valid
// - Gate follows latest command unless a fault overrides
// - Serial interface disabled during primary undervoltage
// - Separate disables, one enable for negative supply
// - Each supply threshold is programmable
// - Six supply flags in two status words
// - Comparator self-test runs at every power-up
// - Self-test injects simulated levels internally only
// - Failed self-test sets its side's fault flag
// - Function self-tests started from two control words
// - Clock fault on stuck or off-frequency oscillator
// - Clock monitors enabled from the startup monitor check on
// - Primary clock fault: flag, safe state, alarm
// - Secondary clock fault: flag, alarm, no gate effect
// - Clock monitor integrity check at every startup
// - Trigger bits emulate a clock failure
// - Self-test fault pulls gate low, maskable alarm
module supply_clock_fault_supervisor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] primarySupplyCode,
  input wire logic [7:0] secposSupplyCode,
  input wire logic [7:0] secnegSupplyCode,
  input wire logic [7:0] primaryUvThreshold,
  input wire logic [7:0] primaryOvThreshold,
  input wire logic [7:0] secposUvThreshold,
  input wire logic [7:0] secposOvThreshold,
  input wire logic [7:0] secnegUvThreshold,
  input wire logic [7:0] secnegOvThreshold,
  input wire logic primaryUvDisable,
  input wire logic primaryOvDisable,
  input wire logic secposUvDisable,
  input wire logic secposOvDisable,
  input wire logic secnegUvovEnable,
  input wire logic [3:0] regMonitorFlags,
  input wire logic intSuppliesOk,
  input wire logic primaryOsc,
  input wire logic secondaryOsc,
  input wire logic enableDriverCmd,
  input wire logic disableDriverCmd,
  input wire logic primaryClockCheckTrigger,
  input wire logic secondaryClockCheckTrigger,
  input wire logic clockFaultSafeState,
  input wire logic primarySelftestAlarmMask,
  input wire logic secondarySelftestAlarmMask,
  input wire logic clkmonSideAAlarmMask,
  input wire logic clkmonSideBAlarmMask,
  input wire logic [3:0] functionTestCtrlA,
  input wire logic [2:0] functionTestCtrlB,
  output logic driverOutputEnable,
  output logic driverGateHigh,
  output logic gateHoldLow,
  output logic spiEnable,
  output logic faultAlarmN,
  output logic [3:0] primaryStatus,
  output logic [5:0] secondaryStatus,
  output logic [1:0] primaryRegInject,
  output logic [1:0] secondaryRegInject,
  output logic [6:0] functionTestStart,
  output logic powerUpDone
);
  localparam logic [9:0] SETTLE_LAST = 10'(supervisor_pkg::SETTLE_CYC - 1);
  localparam logic [9:0] CMBIST_LAST = 10'(supervisor_pkg::CMBIST_CYC - 1);

  // ==========================================================
  // All state of the supervisor
  typedef struct packed {
    supervisor_pkg::supv_state_t state;
    logic [9:0] timer;
    logic [3:0] regSync1; // Regulator monitor flags, first stage
    logic [3:0] regSync2;
    logic intOk1;
    logic intOk;
    logic cmdOn; // Latest driver command
    logic pUv, pOv, sUv2, sOv2, sUv3, sOv3;
    logic stFailP, stFailS; // Sticky self-test faults
    logic clkA, clkB; // Sticky clock monitor faults
    logic seenA, seenB; // Startup monitor check saw a fault
    logic [6:0] ftPrev;
    logic drvEn, gateHigh, holdLow, spiEn, alarmN, upDone;
    logic [1:0] pInj, sInj;
    logic [6:0] ftStart;
  } supv_t;

  supv_t st_reg, st_next;
  logic monEnable, emuA, emuB, faultA, faultB;
  logic rangeOk, supplyValid, supplyFault;
  logic [6:0] ftCtrl;

  // ==========================================================
  // Oscillator watchdogs, one per side
  clock_monitor monA (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(monEnable),
    .emulate(emuA),
    .oscPin(primaryOsc),
    .fault(faultA)
  );

  clock_monitor monB (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(monEnable),
    .emulate(emuB),
    .oscPin(secondaryOsc),
    .fault(faultB)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.regSync1 = regMonitorFlags;
    st_next.regSync2 = st_reg.regSync1;
    st_next.intOk1 = intSuppliesOk;
    st_next.intOk = st_reg.intOk1;
    ftCtrl = {functionTestCtrlB, functionTestCtrlA};
    // Monitors stay off until the sequence reaches the startup monitor check
    monEnable = (st_reg.state == supervisor_pkg::ST_CMBIST) ||
                (st_reg.state == supervisor_pkg::ST_RUN);
    emuA = (st_reg.state == supervisor_pkg::ST_CMBIST) ||
           ((st_reg.state == supervisor_pkg::ST_RUN) && primaryClockCheckTrigger);
    emuB = (st_reg.state == supervisor_pkg::ST_CMBIST) ||
           ((st_reg.state == supervisor_pkg::ST_RUN) && secondaryClockCheckTrigger);
    // Power-up window uses the programmed rising thresholds
    rangeOk = (primarySupplyCode > primaryUvThreshold) &&
              (primarySupplyCode < primaryOvThreshold) &&
              (secposSupplyCode > secposUvThreshold);
    // Disable wins when both commands arrive together
    if (disableDriverCmd) begin
      st_next.cmdOn = 1'b0;
    end else if (enableDriverCmd) begin
      st_next.cmdOn = 1'b1;
    end
    case (st_reg.state)
      supervisor_pkg::ST_POWERUP: begin
        // Wait for supplies before any self-test
        st_next.timer = 10'h000;
        if (rangeOk) begin
          st_next.state = supervisor_pkg::ST_COMPARATOR_SELFTEST_UV;
        end
      end
      supervisor_pkg::ST_COMPARATOR_SELFTEST_UV: begin
        // Simulated low code and regulator UV injection; rails untouched
        if (st_reg.timer == SETTLE_LAST) begin
          if (!(supervisor_pkg::SIM_LOW < primaryUvThreshold) || !st_reg.regSync2[0]) begin
            st_next.stFailP = 1'b1;
          end
          if (!(supervisor_pkg::SIM_LOW < secposUvThreshold) ||
              !(supervisor_pkg::SIM_LOW < secnegUvThreshold) || !st_reg.regSync2[2]) begin
            st_next.stFailS = 1'b1;
          end
          st_next.timer = 10'h000;
          st_next.state = supervisor_pkg::ST_COMPARATOR_SELFTEST_OV;
        end else begin
          st_next.timer = st_reg.timer + 10'h001;
        end
      end
      supervisor_pkg::ST_COMPARATOR_SELFTEST_OV: begin
        // Simulated high code and regulator OV injection
        if (st_reg.timer == SETTLE_LAST) begin
          if (!(supervisor_pkg::SIM_HIGH > primaryOvThreshold) || !st_reg.regSync2[1]) begin
            st_next.stFailP = 1'b1;
          end
          if (!(supervisor_pkg::SIM_HIGH > secposOvThreshold) ||
              !(supervisor_pkg::SIM_HIGH > secnegOvThreshold) || !st_reg.regSync2[3]) begin
            st_next.stFailS = 1'b1;
          end
          st_next.timer = 10'h000;
          st_next.state = supervisor_pkg::ST_CMBIST;
        end else begin
          st_next.timer = st_reg.timer + 10'h001;
        end
      end
      supervisor_pkg::ST_CMBIST: begin
        // Both monitors must flag the emulated failure in time
        if (faultA) begin
          st_next.seenA = 1'b1;
        end
        if (faultB) begin
          st_next.seenB = 1'b1;
        end
        if (st_reg.timer == CMBIST_LAST) begin
          st_next.stFailP = st_reg.stFailP | ~st_next.seenA;
          st_next.stFailS = st_reg.stFailS | ~st_next.seenB;
          st_next.state = supervisor_pkg::ST_RUN;
        end else begin
          st_next.timer = st_reg.timer + 10'h001;
        end
      end
      supervisor_pkg::ST_RUN: begin
        // Clock faults are sticky; only a power cycle clears them
        if (faultA) begin
          st_next.clkA = 1'b1;
        end
        if (faultB) begin
          st_next.clkB = 1'b1;
        end
      end
      default: begin
        st_next.state = supervisor_pkg::ST_POWERUP;
      end
    endcase
    // Live supply flags, gated by their control bits; both negative flags share one enable
    if (st_reg.state == supervisor_pkg::ST_RUN) begin
      st_next.pUv = !primaryUvDisable && (primarySupplyCode < primaryUvThreshold);
      st_next.pOv = !primaryOvDisable && (primarySupplyCode > primaryOvThreshold);
      st_next.sUv2 = !secposUvDisable && (secposSupplyCode < secposUvThreshold);
      st_next.sOv2 = !secposOvDisable && (secposSupplyCode > secposOvThreshold);
      st_next.sUv3 = secnegUvovEnable && (secnegSupplyCode < secnegUvThreshold);
      st_next.sOv3 = secnegUvovEnable && (secnegSupplyCode > secnegOvThreshold);
    end else begin
      st_next.pUv = 1'b0;
      st_next.pOv = 1'b0;
      st_next.sUv2 = 1'b0;
      st_next.sOv2 = 1'b0;
      st_next.sUv3 = 1'b0;
      st_next.sOv3 = 1'b0;
    end
    supplyFault = st_next.pUv | st_next.pOv | st_next.sUv2 | st_next.sOv2 |
                  st_next.sUv3 | st_next.sOv3;
    supplyValid = (st_next.state == supervisor_pkg::ST_RUN) && st_reg.intOk;
    // Gate priority: no supply, self-test, primary clock, supply fault, command
    if (!supplyValid) begin
      st_next.gateHigh = 1'b0;
    end else if (st_next.stFailP || st_next.stFailS) begin
      st_next.gateHigh = 1'b0;
    end else if (st_next.clkA) begin
      st_next.gateHigh = clockFaultSafeState;
    end else if (supplyFault) begin
      st_next.gateHigh = 1'b0;
    end else begin
      st_next.gateHigh = st_next.cmdOn;
    end
    st_next.drvEn = supplyValid;
    st_next.holdLow = !supplyValid;
    st_next.upDone = st_next.state == supervisor_pkg::ST_RUN;
    st_next.spiEn = !(primarySupplyCode < primaryUvThreshold);
    st_next.alarmN = !((st_next.stFailP && !primarySelftestAlarmMask) ||
                       (st_next.stFailS && !secondarySelftestAlarmMask) ||
                       (st_next.clkA && !clkmonSideAAlarmMask) ||
                       (st_next.clkB && !clkmonSideBAlarmMask));
    // Regulator monitor injection only during the comparator self-test
    case (st_next.state)
      supervisor_pkg::ST_COMPARATOR_SELFTEST_UV: begin
        st_next.pInj = supervisor_pkg::INJ_UV;
        st_next.sInj = supervisor_pkg::INJ_UV;
      end
      supervisor_pkg::ST_COMPARATOR_SELFTEST_OV: begin
        st_next.pInj = supervisor_pkg::INJ_OV;
        st_next.sInj = supervisor_pkg::INJ_OV;
      end
      default: begin
        st_next.pInj = supervisor_pkg::INJ_NONE;
        st_next.sInj = supervisor_pkg::INJ_NONE;
      end
    endcase
    // One-cycle start strobe per function test on a rising control bit
    st_next.ftPrev = ftCtrl;
    st_next.ftStart = (st_reg.state == supervisor_pkg::ST_RUN) ?
                      (ftCtrl & ~st_reg.ftPrev) : 7'h00;
  end

  // ==========================================================
  // State register; reset is the power-on reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign driverOutputEnable = st_reg.drvEn;
  assign driverGateHigh = st_reg.gateHigh;
  assign gateHoldLow = st_reg.holdLow;
  assign spiEnable = st_reg.spiEn;
  assign faultAlarmN = st_reg.alarmN;
  assign primaryStatus = {st_reg.clkA, st_reg.stFailP, st_reg.pOv, st_reg.pUv};
  assign secondaryStatus = {st_reg.clkB, st_reg.stFailS, st_reg.sOv3, st_reg.sUv3,
                            st_reg.sOv2, st_reg.sUv2};
  assign primaryRegInject = st_reg.pInj;
  assign secondaryRegInject = st_reg.sInj;
  assign functionTestStart = st_reg.ftStart;
  assign powerUpDone = st_reg.upDone;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_leavePowerup;
    st_reg.state == supervisor_pkg::ST_POWERUP ##1 st_reg.state != supervisor_pkg::ST_POWERUP;
  endsequence
  sequence s_primaryLow;
    primarySupplyCode < primaryUvThreshold;
  endsequence

  a_powerup_entry: assert property (s_leavePowerup |-> st_reg.state == supervisor_pkg::ST_COMPARATOR_SELFTEST_UV)
    else $error("power-up did not start the comparator self-test");
  a_powerup_hold: assert property (st_reg.state == supervisor_pkg::ST_POWERUP && !rangeOk |=>
    st_reg.state == supervisor_pkg::ST_POWERUP)
    else $error("left power-up without valid supplies");
  a_gate_prerun: assert property (st_next.state != supervisor_pkg::ST_RUN |=>
    gateHoldLow && !driverOutputEnable && !driverGateHigh)
    else $error("driver active before supplies valid");
  a_spi_refused: assert property (s_primaryLow |=> !spiEnable)
    else $error("serial interface enabled in primary undervoltage");
  a_uv_flag: assert property ((st_reg.state == supervisor_pkg::ST_RUN && !primaryUvDisable) and
    s_primaryLow |=> primaryStatus[supervisor_pkg::PST_UV])
    else $error("primary undervoltage flag missing");
  a_inject_scope: assert property (primaryRegInject != supervisor_pkg::INJ_NONE |->
    $past(st_next.state) inside {supervisor_pkg::ST_COMPARATOR_SELFTEST_UV, supervisor_pkg::ST_COMPARATOR_SELFTEST_OV})
    else $error("injection outside self-test");
  a_cmd_off: assert property (disableDriverCmd |=>
    !driverGateHigh || (primaryStatus[supervisor_pkg::PST_CLKMON] && $past(clockFaultSafeState)))
    else $error("gate on after disable command");
  a_selftest_low: assert property ((primaryStatus[supervisor_pkg::PST_SELFTEST] ||
    secondaryStatus[supervisor_pkg::SST_SELFTEST]) |=> !driverGateHigh)
    else $error("gate on during self-test fault");
  a_selftest_alarm: assert property (primaryStatus[supervisor_pkg::PST_SELFTEST] &&
    !primarySelftestAlarmMask |=> !faultAlarmN)
    else $error("unmasked self-test fault without alarm");
  a_clka_safe: assert property (st_reg.state == supervisor_pkg::ST_RUN && st_reg.intOk &&
    primaryStatus[supervisor_pkg::PST_CLKMON] && !primaryStatus[supervisor_pkg::PST_SELFTEST] &&
    !secondaryStatus[supervisor_pkg::SST_SELFTEST] |=>
    driverGateHigh == $past(clockFaultSafeState))
    else $error("primary clock fault did not force safe state");
  a_clkb_alarm: assert property (secondaryStatus[supervisor_pkg::SST_CLKMON] &&
    !clkmonSideBAlarmMask |=> !faultAlarmN)
    else $error("unmasked secondary clock fault without alarm");
  a_trigger_fault: assert property (st_reg.state == supervisor_pkg::ST_RUN &&
    $rose(primaryClockCheckTrigger) |-> ##[1:450]
    (primaryStatus[supervisor_pkg::PST_CLKMON] || !primaryClockCheckTrigger))
    else $error("emulated clock failure not flagged");
endmodule

/* File: sim/supply_osc_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Far side: internal oscillators and regulator monitors
module supply_osc_model (
  input wire logic [1:0] primaryRegInject,
  input wire logic [1:0] secondaryRegInject,
  input wire logic stuckA,
  input wire logic intDrop,
  output logic primaryOsc,
  output logic secondaryOsc,
  output logic [3:0] regMonitorFlags,
  output logic intSuppliesOk
);
  logic oscA; // Free running primary oscillator
  logic oscB; // Free running secondary oscillator, own phase
  // 2 MHz oscillators, unrelated in phase to sys_clk and to each other
  initial begin
    oscA = 1'b0;
    #7;
    forever #250 oscA = ~oscA;
  end
  initial begin
    oscB = 1'b0;
    #131;
    forever #250 oscB = ~oscB;
  end
  // Stuck-high primary oscillator on request, otherwise the real clock
  assign primaryOsc = stuckA ? 1'b1 : oscA;
  assign secondaryOsc = oscB;
  // Monitors trip only on the injected level; the rails themselves stay good
  assign regMonitorFlags = {secondaryRegInject == supervisor_pkg::INJ_OV,
    secondaryRegInject == supervisor_pkg::INJ_UV, primaryRegInject == supervisor_pkg::INJ_OV,
    primaryRegInject == supervisor_pkg::INJ_UV};
  // Internal supplies regulate unless the bench pulls them out
  assign intSuppliesOk = ~intDrop;
endmodule

/* File: sim/supply_clock_fault_supervisor_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the supply and clock supervisor
module supply_clock_fault_supervisor_test;
  localparam int SST = 0, PST = 6, PUD = 10, SPI = 11, ALM = 12, HOLD = 13, OE = 14;
  localparam int GATE = 15, FTS = 16;
  typedef struct packed {logic [22:0] m; logic [22:0] v;} exp_t;
  logic sys_clk, rst, pUvDis, pOvDis, sUvDis, sOvDis, nEn, enCmd, disCmd, trigA, trigB;
  logic safeSt, mP, mS, mA, mB, stuckA, oe, gate, hold, spi, alm, pud, pOsc, sOsc, intOk, intDrop;
  logic [7:0] pCode, sCode, nCode, pUv, pOv, sUv, sOv, nUv, nOv;
  logic [3:0] ctrlA, pSt, regFlags;
  logic [2:0] ctrlB;
  logic [5:0] sSt;
  logic [1:0] pInj, sInj;
  logic [6:0] fts;
  logic [22:0] obsV; // All watched outputs but the injection codes in one word
  logic [31:0] seed = 32'h3dce;
  int n_errors = 0;
  int comparisons = 0;
  exp_t q[$]; // Expected results, oldest first
  exp_t cur;
  event probe;
  assign obsV = {fts, gate, oe, hold, alm, spi, pud, pSt, sSt};
  supply_clock_fault_supervisor i_supply_clock_fault_supervisor (.sys_clk(sys_clk), .rst(rst),
    .primarySupplyCode(pCode), .secposSupplyCode(sCode), .secnegSupplyCode(nCode),
    .primaryUvThreshold(pUv), .primaryOvThreshold(pOv), .secposUvThreshold(sUv),
    .secposOvThreshold(sOv), .secnegUvThreshold(nUv), .secnegOvThreshold(nOv),
    .primaryUvDisable(pUvDis), .primaryOvDisable(pOvDis), .secposUvDisable(sUvDis),
    .secposOvDisable(sOvDis), .secnegUvovEnable(nEn), .regMonitorFlags(regFlags),
    .intSuppliesOk(intOk), .primaryOsc(pOsc), .secondaryOsc(sOsc), .enableDriverCmd(enCmd),
    .disableDriverCmd(disCmd), .primaryClockCheckTrigger(trigA),
    .secondaryClockCheckTrigger(trigB), .clockFaultSafeState(safeSt),
    .primarySelftestAlarmMask(mP), .secondarySelftestAlarmMask(mS),
    .clkmonSideAAlarmMask(mA), .clkmonSideBAlarmMask(mB), .functionTestCtrlA(ctrlA),
    .functionTestCtrlB(ctrlB), .driverOutputEnable(oe), .driverGateHigh(gate),
    .gateHoldLow(hold), .spiEnable(spi), .faultAlarmN(alm), .primaryStatus(pSt),
    .secondaryStatus(sSt), .primaryRegInject(pInj), .secondaryRegInject(sInj),
    .functionTestStart(fts), .powerUpDone(pud));
  supply_osc_model i_supply_osc_model (.primaryRegInject(pInj), .secondaryRegInject(sInj),
    .stuckA(stuckA), .intDrop(intDrop), .primaryOsc(pOsc), .secondaryOsc(sOsc),
    .regMonitorFlags(regFlags), .intSuppliesOk(intOk));
  // ==========================================================
  // Helpers
  always #25 sys_clk = ~sys_clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random supply code strictly between the default thresholds
  function logic [7:0] vcode();
    return 8'h41 + 8'(rnd() % 32'h7e);
  endfunction
  task finish_test();
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(logic [22:0] seen, logic [22:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // Note one expected field and hand it to the watcher
  task ex(int lo, int w, logic [22:0] v);
    exp_t e;
    e.m = ((23'h1 << w) - 23'h1) << lo;
    e.v = v << lo;
    q.push_back(e);
    ->probe;
    #0;
  endtask
  // Inputs move 2 ns after the edge, so outputs are settled when sampled
  task tick(int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // Bounded wait for one output bit; running out ends the run
  task waitFor(int b, logic v, int lim);
    int i;
    i = 0;
    while (obsV[b] !== v && i < lim) begin
      tick(1);
      i++;
    end
    if (obsV[b] !== v) begin
      n_errors++;
      $display("CHECK FAILED at %0t: wait on bit %0d timed out", $time, b);
      finish_test();
    end
  endtask
  // Power cycle: thresholds, disables, commands, triggers and controls are written again before release; alarm masks keep their values
  task powerOn(logic [7:0] uv);
    rst = 1'b1;
    {pUv, pOv, sUv, sOv, nUv, nOv} = {uv, 8'hc0, 8'h40, 8'hc0, 8'h40, 8'hc0};
    {pUvDis, pOvDis, sUvDis, sOvDis, nEn, enCmd, disCmd} = 7'h0;
    {trigA, trigB, stuckA, safeSt, ctrlA, ctrlB} = 11'h080;
    tick(16);
    rst = 1'b0;
  endtask
  // ==========================================================
  // Watcher: compares the oldest note whenever a result is due
  always begin
    @(probe);
    while (q.size() > 0) begin
      cur = q.pop_front();
      check(obsV & cur.m, cur.v & cur.m);
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    {mP, mS, mA, mB, intDrop} = 5'h0;
    pCode = 8'h20;
    sCode = vcode();
    nCode = vcode();
    powerOn(8'h40);
    tick(40);
    ex(PUD, 1, 0);
    ex(OE, 2, 0); ex(HOLD, 1, 1);
    ex(SPI, 1, 0);
    pCode = vcode();
    // First self-test phase drives the undervoltage injection on both sides
    tick(1);
    check({19'h0, sInj, pInj}, {19'h0, supervisor_pkg::INJ_UV, supervisor_pkg::INJ_UV});
    waitFor(PUD, 1, 1000);
    ex(PST, 4, 0); ex(SST, 6, 0);
    ex(ALM, 1, 1); ex(SPI, 1, 1);
    enCmd = 1; tick(1); enCmd = 0;
    ex(GATE, 1, 1); ex(OE, 1, 1);
    {enCmd, disCmd} = 2'h3; tick(1); {enCmd, disCmd} = 2'h0;
    ex(GATE, 1, 0);
    enCmd = 1; tick(1); enCmd = 0;
    pCode = 8'hc5; tick(2); ex(PST, 2, 2); ex(GATE, 1, 0);
    pCode = vcode(); tick(2); ex(PST, 2, 0); ex(GATE, 1, 1);
    sUvDis = 1; sCode = 8'h10; tick(2); ex(SST, 1, 0);
    sUvDis = 0; tick(2); ex(SST, 1, 1);
    sCode = vcode(); nCode = 8'hf0; tick(2); ex(SST + supervisor_pkg::SST_NEG_OV, 1, 0);
    nEn = 1; tick(2); ex(SST + supervisor_pkg::SST_NEG_OV, 1, 1);
    nCode = vcode(); sUv = sCode + 8'h1; tick(2); ex(SST, 1, 1);
    sUv = 8'h40; tick(2); ex(SST, 6, 0); ex(GATE, 1, 1);
    // Internal supplies leave regulation: two sync stages, then the driver lets go
    intDrop = 1;
    tick(3);
    ex(OE, 2, 0); ex(HOLD, 1, 1);
    intDrop = 0;
    tick(3);
    ex(OE, 2, 3);
    for (int i = 0; i < 7; i++) begin
      {ctrlB, ctrlA} = 7'h1 << i; tick(1); ex(FTS, 7, 7'h1 << i);
      tick(1); ex(FTS, 7, 0); {ctrlB, ctrlA} = 7'h0;
      tick(1);
    end
    trigB = 1; waitFor(SST + supervisor_pkg::SST_CLKMON, 1, 1000);
    tick(1); ex(ALM, 1, 0); ex(GATE, 1, 1); ex(PST, 4, 0);
    trigB = 0; disCmd = 1; tick(1); disCmd = 0; ex(GATE, 1, 0);
    stuckA = 1; waitFor(PST + supervisor_pkg::PST_CLKMON, 1, 1000);
    tick(1); ex(GATE, 1, 1);
    // Second power cycle with an unusable threshold: self-test must fail
    mP = 1; powerOn(8'h00); waitFor(PUD, 1, 1000);
    ex(PST + supervisor_pkg::PST_SELFTEST, 1, 1); ex(ALM, 1, 1);
    enCmd = 1; tick(1); enCmd = 0; ex(GATE, 1, 0);
    trigA = 1; waitFor(PST + supervisor_pkg::PST_CLKMON, 1, 1000); tick(1);
    ex(GATE, 1, 0); ex(ALM, 1, 0);
    tick(2);
    finish_test();
  end
endmodule
